// ===== tsr_pkg.sv
package tsr_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_CONTACTS = 7;
	localparam int NUM_SIG_LEDS = 8;
	localparam int STAT_W = 16;
	localparam int FRAME_BITS = STAT_W + 1;
	localparam int BITCNT_W = 5;
	localparam int DELAY_W = 14;
	localparam int SRC_W = 4;
	localparam int IDX_W = 4;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int DELAY_STEP_MS = 10;
	localparam int DELAY_MAX_S = 100;
	localparam int DELAY_MAX_STEPS = DELAY_MAX_S * 1000 / DELAY_STEP_MS;
	localparam int DELAY_STEP_CYC = DELAY_STEP_MS * 1000000 / CLK_PERIOD_NS;
	localparam int LINK_TIMEOUT_MS = 100;
	localparam int LINK_TIMEOUT_TICKS = LINK_TIMEOUT_MS / DELAY_STEP_MS;
	localparam int TO_W = 4;
	localparam int BIT_GAP_US = 50;
	localparam int BIT_GAP_CYC = BIT_GAP_US * 1000 / CLK_PERIOD_NS;
	localparam int GAP_W = 9;

	// ----------------------------------------------------------------
	// status word bit positions
	// ----------------------------------------------------------------
	localparam int ST_L_PREALARM = 0;
	localparam int ST_L_TIMING = 1;
	localparam int ST_S_TIMING = 2;
	localparam int ST_L_TRIP = 3;
	localparam int ST_S_TRIP = 4;
	localparam int ST_G_TRIP = 5;
	localparam int ST_I_TRIP = 6;
	localparam int ST_OVERHEAT = 7;
	localparam int ST_LOAD_A = 8;
	localparam int ST_LOAD_B = 9;
	localparam int ST_PHASE_UNBAL = 10;
	localparam int ST_UNDERVOLTAGE_TRIP = 11;
	localparam int ST_OVERVOLTAGE_TRIP = 12;
	localparam int ST_REVERSE_POWER_TRIP = 13;
	localparam int ST_DIRECTIONAL_TRIP = 14;
	localparam int ST_TRIPPED = 15;

	// ----------------------------------------------------------------
	// source selector codes
	// ----------------------------------------------------------------
	localparam logic [SRC_W-1:0] SRC_NONE = 4'h0;
	localparam logic [SRC_W-1:0] SRC_L_PREALARM = 4'h1;
	localparam logic [SRC_W-1:0] SRC_L_TIMING = 4'h2;
	localparam logic [SRC_W-1:0] SRC_S_TIMING = 4'h3;
	localparam logic [SRC_W-1:0] SRC_L_TRIP = 4'h4;
	localparam logic [SRC_W-1:0] SRC_S_TRIP = 4'h5;
	localparam logic [SRC_W-1:0] SRC_G_TRIP = 4'h6;
	localparam logic [SRC_W-1:0] SRC_I_TRIP = 4'h7;
	localparam logic [SRC_W-1:0] SRC_ANY_TRIP = 4'h8;
	localparam logic [SRC_W-1:0] SRC_CUSTOM = 4'h9;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RX_IDLE = 2'h1,
		RX_BITS = 2'h2
	} tsr_rx_t;

	typedef struct packed {
		logic [SRC_W-1:0] src;
		logic [IDX_W-1:0] custom_bit;
		logic [DELAY_W-1:0] delay;
		logic nc;
		logic latch;
	} tsr_cfg_t;

	typedef struct packed {
		logic prealarm;
		logic timing_trip;
		logic i_trip;
		logic overheat;
		logic load_a;
		logic load_b;
		logic release_trip;
		logic link_err;
		logic phase_unbal;
	} tsr_fixed_t;

endpackage

// ===== tsr_relay_unit.sv
`timescale 1ns/1ps

module tsr_relay_unit #(
	parameter int TICK_CYC = tsr_pkg::DELAY_STEP_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// serial status line from the release
	input wire logic link_clk_pin,
	input wire logic link_dat_pin,
	// front reset button, pressed when low
	input wire logic reset_btn_n,
	// per contact configuration
	input wire tsr_pkg::tsr_cfg_t [tsr_pkg::NUM_CONTACTS-1:0] cfg,
	// fixed outputs
	output tsr_pkg::tsr_fixed_t fixed,
	// programmable contacts, high when closed
	output logic [tsr_pkg::NUM_CONTACTS-1:0] contact,
	// front LEDs
	output logic led_power,
	output logic led_tx,
	output logic [tsr_pkg::NUM_SIG_LEDS-1:0] led_sig
);

	localparam int TICK_W = $clog2(TICK_CYC + 1);
	localparam int NC = tsr_pkg::NUM_CONTACTS;
	localparam int SW = tsr_pkg::STAT_W;
	localparam int FB = tsr_pkg::FRAME_BITS;
	localparam int DW = tsr_pkg::DELAY_W;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] clk_s;
		logic [1:0] dat_s;
		logic [1:0] btn_s;
		tsr_pkg::tsr_rx_t rx;
		logic [FB-1:0] sr;
		logic [tsr_pkg::BITCNT_W-1:0] bitcnt;
		logic [tsr_pkg::GAP_W-1:0] gap;
		logic [SW-1:0] stat;
		logic [TICK_W-1:0] tick_cnt;
		logic tick;
		logic [tsr_pkg::TO_W-1:0] to_cnt;
		logic [NC-1:0][DW-1:0] dcnt;
		logic [NC-1:0] act;
		logic [NC-1:0] contact;
		tsr_pkg::tsr_fixed_t fixed;
		logic [tsr_pkg::NUM_SIG_LEDS-1:0] led_sig;
		logic led_tx;
		logic led_power;
	} tsr_state_t;

	// button stages start at the released level, so reset gives no press
	localparam tsr_state_t ST_RESET = '{
		clk_s: 3'h0,
		dat_s: 2'h0,
		btn_s: 2'h3,
		rx: tsr_pkg::RX_IDLE,
		sr: '0,
		bitcnt: '0,
		gap: '0,
		stat: '0,
		tick_cnt: '0,
		tick: 1'b0,
		to_cnt: '0,
		dcnt: '0,
		act: '0,
		contact: '0,
		fixed: '0,
		led_sig: '0,
		led_tx: 1'b0,
		led_power: 1'b0
	};

	tsr_state_t st;
	tsr_state_t next_st;

	// ----------------------------------------------------------------
	// source decode
	// ----------------------------------------------------------------
	function automatic logic any_trip_of(
		input logic [SW-1:0] s
	);
		any_trip_of = s[tsr_pkg::ST_L_TRIP] |
			s[tsr_pkg::ST_S_TRIP] |
			s[tsr_pkg::ST_G_TRIP] |
			s[tsr_pkg::ST_I_TRIP] |
			s[tsr_pkg::ST_UNDERVOLTAGE_TRIP] |
			s[tsr_pkg::ST_OVERVOLTAGE_TRIP] |
			s[tsr_pkg::ST_REVERSE_POWER_TRIP] |
			s[tsr_pkg::ST_DIRECTIONAL_TRIP] |
			s[tsr_pkg::ST_TRIPPED];
	endfunction

	// ----------------------------------------------------------------
	// delay range
	// ----------------------------------------------------------------
	// steps beyond the documented range saturate at the maximum
	function automatic logic [DW-1:0] clamp_delay(
		input logic [DW-1:0] d
	);
		if (d > DW'(tsr_pkg::DELAY_MAX_STEPS)) begin
			clamp_delay = DW'(tsr_pkg::DELAY_MAX_STEPS);
		end else begin
			clamp_delay = d;
		end
	endfunction

	function automatic logic src_pick(
		input tsr_pkg::tsr_cfg_t c,
		input logic [SW-1:0] s
	);
		case (c.src)
			tsr_pkg::SRC_NONE: src_pick = 1'b0;
			tsr_pkg::SRC_L_PREALARM: src_pick = s[tsr_pkg::ST_L_PREALARM];
			tsr_pkg::SRC_L_TIMING: src_pick = s[tsr_pkg::ST_L_TIMING];
			tsr_pkg::SRC_S_TIMING: src_pick = s[tsr_pkg::ST_S_TIMING];
			tsr_pkg::SRC_L_TRIP: src_pick = s[tsr_pkg::ST_L_TRIP];
			tsr_pkg::SRC_S_TRIP: src_pick = s[tsr_pkg::ST_S_TRIP];
			tsr_pkg::SRC_G_TRIP: src_pick = s[tsr_pkg::ST_G_TRIP];
			tsr_pkg::SRC_I_TRIP: src_pick = s[tsr_pkg::ST_I_TRIP];
			tsr_pkg::SRC_ANY_TRIP: src_pick = any_trip_of(s);
			tsr_pkg::SRC_CUSTOM: src_pick = s[c.custom_bit];
			default: src_pick = 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic clk_rise;
		logic btn;
		logic frame_ok;
		logic src;
		logic [DW-1:0] dly;
		logic [SW-1:0] s;
		clk_rise = 1'b0;
		btn = 1'b0;
		frame_ok = 1'b0;
		src = 1'b0;
		dly = '0;
		s = '0;
		next_st = st;

		// synchronisers; first stages feed only the second
		// the link clock has a third stage that only the edge detect reads
		next_st.clk_s = {st.clk_s[1], st.clk_s[0], link_clk_pin};
		next_st.dat_s = {st.dat_s[0], link_dat_pin};
		next_st.btn_s = {st.btn_s[0], reset_btn_n};
		clk_rise = st.clk_s[1] & ~st.clk_s[2];
		btn = ~st.btn_s[1];
		next_st.led_power = 1'b1;

		// 10 ms step tick
		// one tick paces both the contact delays and the link watchdog
		next_st.tick = 1'b0;
		if (st.tick_cnt == TICK_W'(TICK_CYC - 1)) begin
			next_st.tick_cnt = '0;
			next_st.tick = 1'b1;
		end else begin
			next_st.tick_cnt = st.tick_cnt + TICK_W'(1);
		end

		// frame receiver: 16 status bits msb first, then even parity
		// a stall of the bit gap limit mid frame drops the partial word
		case (st.rx)
			tsr_pkg::RX_IDLE: begin
				next_st.gap = '0;
				next_st.bitcnt = '0;
				if (clk_rise) begin
					next_st.sr = {st.sr[FB-2:0], st.dat_s[1]};
					next_st.bitcnt = tsr_pkg::BITCNT_W'(1);
					next_st.rx = tsr_pkg::RX_BITS;
				end
			end
			tsr_pkg::RX_BITS: begin
				if (clk_rise) begin
					next_st.sr = {st.sr[FB-2:0], st.dat_s[1]};
					next_st.gap = '0;
					if (st.bitcnt == tsr_pkg::BITCNT_W'(FB - 1)) begin
						frame_ok = ~^next_st.sr;
						next_st.bitcnt = '0;
						next_st.rx = tsr_pkg::RX_IDLE;
					end else begin
						next_st.bitcnt = st.bitcnt + tsr_pkg::BITCNT_W'(1);
					end
				end else if (st.gap ==
					tsr_pkg::GAP_W'(tsr_pkg::BIT_GAP_CYC - 1)) begin
					next_st.bitcnt = '0;
					next_st.rx = tsr_pkg::RX_IDLE;
				end else begin
					next_st.gap = st.gap + tsr_pkg::GAP_W'(1);
				end
			end
			default: begin
				next_st.rx = tsr_pkg::RX_IDLE;
			end
		endcase

		// link supervision
		// a valid frame beats a timeout in one cycle, as it proves the link
		// a timeout drops stale status so no contact acts on old news
		if (frame_ok) begin
			next_st.stat = next_st.sr[FB-1:1];
			next_st.to_cnt = '0;
			next_st.fixed.link_err = 1'b0;
			next_st.led_tx = ~st.led_tx;
		end else if (st.tick) begin
			if (st.to_cnt ==
				tsr_pkg::TO_W'(tsr_pkg::LINK_TIMEOUT_TICKS - 1)) begin
				next_st.fixed.link_err = 1'b1;
				next_st.stat = '0;
			end else begin
				next_st.to_cnt = st.to_cnt + tsr_pkg::TO_W'(1);
			end
		end

		// fixed outputs
		// the release reports its tripped state in the top status bit
		s = st.stat;
		next_st.fixed.prealarm = s[tsr_pkg::ST_L_PREALARM] &
			~s[tsr_pkg::ST_TRIPPED];
		next_st.fixed.timing_trip = s[tsr_pkg::ST_L_TIMING] |
			s[tsr_pkg::ST_S_TIMING] | s[tsr_pkg::ST_TRIPPED];
		next_st.fixed.i_trip = s[tsr_pkg::ST_I_TRIP];
		next_st.fixed.overheat = s[tsr_pkg::ST_OVERHEAT];
		next_st.fixed.load_a = s[tsr_pkg::ST_LOAD_A];
		next_st.fixed.load_b = s[tsr_pkg::ST_LOAD_B];
		next_st.fixed.release_trip = s[tsr_pkg::ST_TRIPPED];
		next_st.fixed.phase_unbal = s[tsr_pkg::ST_PHASE_UNBAL];

		// sticky indicator LEDs, a new event wins over the button
		next_st.led_sig = (st.led_sig & {tsr_pkg::NUM_SIG_LEDS{~btn}}) |
			{st.fixed.prealarm,
			st.fixed.timing_trip,
			st.fixed.i_trip,
			st.fixed.overheat,
			st.fixed.release_trip,
			st.fixed.link_err,
			st.fixed.phase_unbal,
			st.fixed.load_a | st.fixed.load_b};

		// programmable contacts
		// the button holds every count at zero, so delays restart on release
		for (int i = 0; i < NC; i++) begin
			src = src_pick(cfg[i], st.stat);
			dly = clamp_delay(cfg[i].delay);
			if (!src || btn) begin
				next_st.dcnt[i] = '0;
			end else if (st.tick && st.dcnt[i] < dly) begin
				next_st.dcnt[i] = st.dcnt[i] + DW'(1);
			end
			if (btn) begin
				next_st.act[i] = 1'b0;
			end else if (cfg[i].latch) begin
				next_st.act[i] = st.act[i] |
					(src && st.dcnt[i] >= dly);
			end else begin
				next_st.act[i] = src && st.dcnt[i] >= dly;
			end
			next_st.contact[i] = st.act[i] ^ cfg[i].nc;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st <= ST_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign fixed = st.fixed;
	// contacts sit open in reset, whatever their resting sense
	assign contact = st.contact;
	assign led_power = st.led_power;
	assign led_tx = st.led_tx;
	assign led_sig = st.led_sig;

endmodule // tsr_relay_unit

// ===== tsr_release_model.sv
`timescale 1ns/1ps
module tsr_release_model (
	// handshake from the bench
	input wire logic mclk,
	input wire logic go,
	input wire logic bad,
	input wire logic [15:0] status,
	output logic busy,
	// serial line towards the unit
	output logic link_clk_pin,
	output logic link_dat_pin
);
	logic [16:0] sh;
	logic [4:0] nbit;
	logic [2:0] ph;
	initial begin
		busy = 1'b0;
		link_clk_pin = 1'b0;
		link_dat_pin = 1'b0;
	end
	// idle release holds the clock low and toggles the data line every cycle
	always @(posedge mclk) begin
		if (!busy) begin
			link_clk_pin <= 1'b0;
			link_dat_pin <= ~link_dat_pin;
			if (go) begin
				busy <= 1'b1;
				sh <= {status, ^status ^ bad};
				nbit <= 5'h00;
				ph <= 3'h0;
				link_dat_pin <= status[15];
			end
		end else begin
			ph <= ph + 3'h1;
			if (ph == 3'h3)
				link_clk_pin <= 1'b1;
			if (ph == 3'h7) begin
				link_clk_pin <= 1'b0;
				nbit <= nbit + 5'h01;
				sh <= sh << 1;
				link_dat_pin <= sh[15];
				if (nbit == 5'h10)
					busy <= 1'b0;
			end
		end
	end
endmodule // tsr_release_model

// ===== tsr_relay_unit_asserts.sv
`timescale 1ns/1ps
module tsr_relay_unit_asserts #(
	parameter int TICK_CYC = 10
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic link_clk_pin,
	input wire logic link_dat_pin,
	input wire logic reset_btn_n,
	input wire tsr_pkg::tsr_cfg_t [tsr_pkg::NUM_CONTACTS-1:0] cfg,
	input wire tsr_pkg::tsr_fixed_t fixed,
	input wire logic [tsr_pkg::NUM_CONTACTS-1:0] contact,
	input wire logic led_power,
	input wire logic led_tx,
	input wire logic [tsr_pkg::NUM_SIG_LEDS-1:0] led_sig
);
	localparam int LIM = 11 * TICK_CYC + 10;
	logic [31:0] idle;
	logic tx_q;
	logic [tsr_pkg::NUM_CONTACTS-1:0] nc_v;
	always_comb begin
		for (int i = 0; i < tsr_pkg::NUM_CONTACTS; i++)
			nc_v[i] = cfg[i].nc;
	end
	// cycles since the last accepted frame
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			idle <= 32'h0;
			tx_q <= 1'b0;
		end else begin
			tx_q <= led_tx;
			if (led_tx != tx_q)
				idle <= 32'h0;
			else if (idle < LIM)
				idle <= idle + 32'h1;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	sequence s_btn_held;
		(!reset_btn_n && $stable(nc_v)) [*6];
	endsequence
	sequence s_src_idle;
		(cfg[0].src == tsr_pkg::SRC_NONE && !cfg[0].latch &&
			$stable(cfg[0].nc)) [*3];
	endsequence
	a_prealarm_trip:
		assert property (fixed.prealarm |-> !fixed.release_trip)
		else $error("prealarm while tripped");
	a_timing_hold:
		assert property (fixed.release_trip |-> fixed.timing_trip)
		else $error("timing output low while tripped");
	a_power_led:
		assert property ($past(nrst) |-> led_power)
		else $error("power led low");
	a_btn_rest:
		assert property (s_btn_held |-> contact == nc_v)
		else $error("contacts not at rest");
	a_src_quiet:
		assert property (s_src_idle |-> contact[0] == cfg[0].nc)
		else $error("idle source moved contact");
	a_led_prealarm:
		assert property (fixed.prealarm |=> led_sig[7])
		else $error("prealarm led not set");
	a_led_trip:
		assert property (fixed.release_trip |=> led_sig[3])
		else $error("trip led not set");
	a_link_timeout:
		assert property (idle >= LIM && led_tx == tx_q |-> fixed.link_err)
		else $error("link error missing");
endmodule // tsr_relay_unit_asserts

bind tsr_relay_unit tsr_relay_unit_asserts #(.TICK_CYC(TICK_CYC)) i_asserts (
	.mclk(mclk), .nrst(nrst), .link_clk_pin(link_clk_pin),
	.link_dat_pin(link_dat_pin), .reset_btn_n(reset_btn_n), .cfg(cfg),
	.fixed(fixed), .contact(contact), .led_power(led_power),
	.led_tx(led_tx), .led_sig(led_sig));

// ===== tsr_relay_unit_tb_top.sv
`timescale 1ns/1ps
module tsr_relay_unit_tb_top;
	localparam int TK = 20;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic reset_btn_n = 1'b1;
	logic go = 1'b0;
	logic bad = 1'b0;
	logic [15:0] status = 16'h0000;
	logic busy, link_clk_pin, link_dat_pin, led_power, led_tx, t;
	logic [6:0] contact;
	logic [7:0] led_sig;
	logic [15:0] s;
	tsr_pkg::tsr_fixed_t fixed;
	tsr_pkg::tsr_cfg_t [6:0] cfg = '0;
	int fail_count = 0;
	int check_count = 0;
	always #50 mclk = ~mclk;
	tsr_relay_unit #(.TICK_CYC(TK)) i_dut (.mclk(mclk), .nrst(nrst),
		.link_clk_pin(link_clk_pin), .link_dat_pin(link_dat_pin),
		.reset_btn_n(reset_btn_n), .cfg(cfg), .fixed(fixed),
		.contact(contact), .led_power(led_power), .led_tx(led_tx),
		.led_sig(led_sig));
	tsr_release_model i_rel (.mclk(mclk), .go(go), .bad(bad),
		.status(status), .busy(busy), .link_clk_pin(link_clk_pin),
		.link_dat_pin(link_dat_pin));
	function automatic tsr_pkg::tsr_fixed_t exp_fix(logic [15:0] v);
		exp_fix = '{prealarm: v[0] & ~v[15], timing_trip: v[1] | v[2] | v[15],
			i_trip: v[6], overheat: v[7], load_a: v[8], load_b: v[9],
			release_trip: v[15], link_err: 1'b0, phase_unbal: v[10]};
	endfunction
	function automatic logic exp_src(logic [3:0] c, logic [3:0] b,
		logic [15:0] v);
		case (c)
			4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: exp_src = v[c - 4'h1];
			4'h8: exp_src = |{v[15:11], v[6:3]};
			4'h9: exp_src = v[b];
			default: exp_src = 1'b0;
		endcase
	endfunction
	task automatic step(int n);
		repeat (n) @(posedge mclk);
		#10;
	endtask
	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic send(logic [15:0] v, logic b);
		go = 1'b1;
		status = v;
		bad = b;
		step(1);
		go = 1'b0;
		for (int n = 0; n < 300 && busy; n++)
			step(1);
		if (busy)
			fail_count++;
		step(5);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		print_verdict();
	end
	initial begin
		void'($urandom(32'hB234FDFD));
		step(6);
		nrst = 1'b1;
		step(2);
		chk("led_power", led_power, 1);
		for (int i = 0; i < 20; i++) begin
			s = $urandom;
			t = led_tx;
			send(s, 1'b0);
			chk("fixed", fixed, exp_fix(s));
			chk("led_tx", led_tx, !t);
		end
		send(~s, 1'b1);
		chk("fixed", fixed, exp_fix(s));
		$display("test fixed outputs done");
		for (int r = 0; r < 4; r++) begin
			for (int i = 0; i < 7; i++) begin
				cfg[i].src = 4'((r * 7 + i) % 10);
				cfg[i].custom_bit = 4'($urandom);
				cfg[i].nc = 1'($urandom);
			end
			s = $urandom;
			send(s, 1'b0);
			for (int i = 0; i < 7; i++)
				chk("contact", contact[i], exp_src(cfg[i].src,
					cfg[i].custom_bit, s) ^ cfg[i].nc);
		end
		$display("test sources done");
		send(16'h0000, 1'b0);
		cfg = '0;
		cfg[0].src = tsr_pkg::SRC_L_TRIP;
		cfg[0].delay = 14'h0012;
		cfg[1].src = tsr_pkg::SRC_L_TRIP;
		cfg[1].nc = 1'b1;
		cfg[1].latch = 1'b1;
		send(16'h0008, 1'b0);
		chk("contact1", contact[1], 0);
		send(16'h0000, 1'b0);
		chk("contact1", contact[1], 0);
		repeat (3) send(16'h0008, 1'b0);
		chk("contact0", contact[0], 0);
		send(16'h0008, 1'b0);
		chk("contact0", contact[0], 1);
		send(16'h0000, 1'b0);
		chk("contact0", contact[0], 0);
		reset_btn_n = 1'b0;
		step(6);
		chk("contact", contact, 7'h02);
		chk("led_sig", led_sig, 8'h00);
		reset_btn_n = 1'b1;
		step(4);
		chk("contact1", contact[1], 1);
		$display("test delay and latch done");
		step(12 * TK);
		chk("link_err", fixed.link_err, 1);
		chk("led_link", led_sig[2], 1);
		send(16'h0000, 1'b0);
		chk("link_err", fixed.link_err, 0);
		$display("test link timeout done");
		print_verdict();
	end
endmodule // tsr_relay_unit_tb_top
